// ===== bench/hfc_remote.sv
// Remote station model: sends frames and C/I values, counts line flags.
`timescale 1ns/100ps
// ==========================================================================
// Remote station
module hfc_remote #(
  parameter int DIV = 2
) (
  input wire logic clk_i,
  input wire logic tx_bit_i,
  output hfc_pkg::hfc_rx_t rx_o,
  output logic [3:0] ci0_o,
  output logic [3:0] ci1_o,
  output int flags_o
);
  import hfc_pkg::*;
  int run;

  initial begin
    rx_o = '0;
    ci0_o = 4'h0;
    ci1_o = 4'h0;
    flags_o = 0;
    run = 0;
  end

  // Stuffing leaves six ones between zeros only inside a flag, so an
  // exact run of six bit times is counted as one flag.
  always @(posedge clk_i) begin
    if (tx_bit_i === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run == 6 * DIV) begin
        flags_o <= flags_o + 1;
      end
      run <= 0;
    end
  end

  // Once the strobe is gone the data lines hold the inverted last byte for one cycle, then the last byte again.
  task automatic send(input int n, input logic [7:0] b, input bit eof);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      rx_o <= '{vld: 1'b1, eof: 1'b0, dat: b + 8'(k)};
    end
    @(posedge clk_i);
    rx_o <= '{vld: 1'b0, eof: eof, dat: ~rx_o.dat};
    @(posedge clk_i);
    rx_o <= '{vld: 1'b0, eof: 1'b0, dat: ~rx_o.dat};
  endtask

  task automatic set_ci(input logic [3:0] a, input logic [3:0] c);
    @(posedge clk_i);
    ci0_o <= a;
    ci1_o <= c;
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking testbench of the HDLC FIFO and command block.
`timescale 1ns/100ps
// ==========================================================================
// Testbench
module tb;
  import hfc_pkg::*;
  localparam logic [7:0] A_IRQ = {IX_IRQ, 2'b00};
  localparam logic [7:0] A_CTL = {IX_CTRL, 2'b00};
  localparam logic [7:0] A_MODE = {IX_MODE, 2'b00};
  localparam logic [7:0] A_CNT = {IX_CNT, 2'b00};
  localparam logic [7:0] A_TMR = {IX_TIMER, 2'b00};
  localparam logic [7:0] A_EXT = {IX_EXT, 2'b00};
  localparam logic [7:0] A_CI0 = {IX_CI0, 2'b00};
  localparam logic [7:0] A_CI1 = {IX_CI1, 2'b00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  hfc_rx_t rx;
  logic [3:0] ci0;
  logic [3:0] ci1;
  logic tx_bit_o;
  logic int_o;
  int flags;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] seed = 8'h3D;

  always #5 clk_i = ~clk_i;

  hfc_top #(.DCL_DIV(2), .T1_CYC(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .rx_i(rx), .ci0_i(ci0),
    .ci1_i(ci1), .tx_bit_o(tx_bit_o), .int_o(int_o));
  hfc_remote #(.DIV(2)) peer (.clk_i(clk_i), .tx_bit_i(tx_bit_o),
    .rx_o(rx), .ci0_o(ci0), .ci1_o(ci1), .flags_o(flags));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] e, string m);
    n_compared++;
    if (got !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, e);
    end
  endtask

  // Request held until ack is sampled high; a missing ack is an error.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 40) begin
      chk(8'h00, 8'h01, "no ack");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, string m);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e, m);
  endtask

  task automatic rx_block(input int n, input logic [7:0] b);
    logic [7:0] q;
    for (int k = 0; k < n; k++) begin
      wb(1'b0, 8'(4 * (k % 32)), 8'h00, q);
      chk(q, b + 8'(k), "rx byte");
    end
    wr(A_CTL, 8'h80);
  endtask

  task automatic short_frame(input int n, input logic [7:0] b);
    peer.send(n, b, 1'b1);
    repeat (4) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h80, "message end");
    rd_chk(A_IRQ, 8'h00, "clear on read");
    rd_chk(A_CNT, 8'(n), "count");
    rx_block(n, b);
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    logic [7:0] q;
    int n;
    int f0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(A_IRQ, 8'h00, "irq reset");
    rd_chk(A_CTL, 8'h48, "status reset");
    rd_chk(8'hA0, 8'h00, "unmapped");
    // Transparent mode keeps auto-mode replies off the line.
    wr(A_MODE, 8'hC8);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      n = (i == 0) ? 32 : 1 + int'(seed[4:0]);
      seed = lfsr(seed);
      short_frame(n, seed);
    end
    peer.send(40, 8'h10, 1'b1);
    repeat (4) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h40, "pool full");
    rd_chk(A_CNT, 8'h20, "block");
    rx_block(32, 8'h10);
    repeat (4) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h80, "tail end");
    rd_chk(A_CNT, 8'h08, "tail count");
    rx_block(8, 8'h30);
    peer.send(40, 8'h50, 1'b0);
    repeat (4) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h40, "pool full");
    wr(A_CTL, 8'h40);
    short_frame(3, 8'hA0);
    wr(A_IRQ, 8'h80);
    peer.send(2, 8'h66, 1'b1);
    repeat (4) @(posedge clk_i);
    chk({7'h0, int_o}, 8'h00, "pin masked");
    rd_chk(A_IRQ, 8'h00, "hidden");
    wr(A_IRQ, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({7'h0, int_o}, 8'h01, "pin up");
    rd_chk(A_IRQ, 8'h80, "pending");
    repeat (3) @(posedge clk_i);
    chk({7'h0, int_o}, 8'h00, "pin down");
    rx_block(2, 8'h66);
    peer.set_ci(4'h5, 4'h0);
    repeat (4) @(posedge clk_i);
    chk({7'h0, int_o}, 8'h01, "pin cic");
    rd_chk(A_IRQ, 8'h04, "cic set");
    rd_chk(A_IRQ, 8'h04, "cic stays");
    rd_chk(A_CI0, 8'h05, "ci0");
    rd_chk(A_IRQ, 8'h00, "cic gone");
    wr(A_IRQ, 8'h04);
    peer.set_ci(4'h5, 4'hA);
    repeat (4) @(posedge clk_i);
    chk({7'h0, int_o}, 8'h00, "cic no pin");
    rd_chk(A_IRQ, 8'h04, "cic masked");
    rd_chk(A_CI1, 8'h0A, "ci1");
    wr(A_IRQ, 8'h00);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      n = 1 + int'(seed[4:0]);
      for (int k = 0; k < n; k++) begin
        seed = lfsr(seed);
        wr(8'(4 * k), seed);
      end
      f0 = flags;
      wr(A_CTL, 8'h0A);
      q = 8'h00;
      for (int t = 0; t < 300 && q === 8'h00; t++) begin
        wb(1'b0, A_IRQ, 8'h00, q);
      end
      chk(q, 8'h10, "pool ready");
      repeat (8) @(posedge clk_i);
      chk(8'(flags - f0), 8'h02, "two flags");
    end
    for (int k = 0; k < 33; k++) begin
      wr(8'h00, 8'(k));
    end
    wb(1'b0, A_CTL, 8'h00, q);
    chk(q & 8'h80, 8'h80, "overflow");
    f0 = flags;
    wr(A_CTL, 8'h0A);
    repeat (40) @(posedge clk_i);
    wr(A_CTL, 8'h01);
    repeat (300) @(posedge clk_i);
    chk(8'(flags - f0), 8'h01, "aborted");
    chk({7'h0, tx_bit_o}, 8'h01, "line idle");
    // Auto-mode: received S- and I-frames move remote and local state.
    wr(A_MODE, 8'h08);
    peer.send(2, 8'h04, 1'b1);
    repeat (4) @(posedge clk_i);
    rd_chk(A_IRQ, 8'hA0, "remote change");
    rd_chk(A_CTL, 8'h58, "remote busy");
    rx_block(2, 8'h04);
    wr(A_CTL, 8'h20);
    rd_chk(A_CTL, 8'h78, "local busy");
    f0 = flags;
    peer.send(3, 8'h11, 1'b1);
    repeat (200) @(posedge clk_i);
    chk(8'(flags - f0), 8'h02, "reply sent");
    rd_chk(A_IRQ, 8'h80, "i-frame end");
    rx_block(3, 8'h11);
    // An unfinished frame left without a further command must underrun.
    wr(8'h00, 8'h55);
    wr(A_CTL, 8'h08);
    repeat (80) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h11, "underrun");
    rd_chk(A_EXT, 8'h40, "underrun cause");
    wr(A_TMR, 8'h01);
    wr(A_CTL, 8'h10);
    repeat (60) @(posedge clk_i);
    rd_chk(A_IRQ, 8'h08, "timer expired");
    final_report();
  end
endmodule

// ===== hdl/hfc_top.sv
// HDLC controller FIFO and command interface with Wishbone register access.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module hfc_top #(
  parameter int DCL_DIV = hfc_pkg::DCL_DIV_DEF,
  parameter int T1_CYC = hfc_pkg::T1_UNIT_CYC,
  parameter logic [7:0] LOCAL_ADDR = hfc_pkg::LOCAL_ADDR_DEF
) (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input hfc_pkg::hfc_rx_t rx_i,
  input logic [3:0] ci0_i,
  input logic [3:0] ci1_i,
  output logic tx_bit_o,
  output logic int_o
);
  import hfc_pkg::*;

  hfc_st_t q, d;
  logic req, wr, rd, bit_t, bnd, auto, drop_now, nrr, b, fb;
  logic ld, ls, lc;
  logic [5:0] ix, tlen;
  logic [7:0] clr, set, interrupt_status, cmd, lb, src;
  logic [6:0] used;
  logic [1:0] alen;

  // =====================================================================
  // Next-state logic
  always_comb begin
    d = q;
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    rd = req & ~wb_we_i;
    ix = wb_adr_i[7:2];
    cmd = (wr && ix == IX_CTRL) ? wb_dat_i[7:0] : 8'h00;
    auto = q.mds[2:1] == MDS_AUTO;
    alen = q.mds[0] ? 2'h2 : 2'h1;
    used = q.wp - q.base;
    tlen = q.twp[5] ? POOL : q.twp;
    clr = 8'h00;
    set = 8'h00;
    ld = 1'b0;
    lb = 8'h00;
    ls = 1'b0;
    lc = 1'b0;
    b = q.sh[0];
    fb = q.crc[0] ^ q.sh[0];
    nrr = q.ctl[3:2] == S_RNR;
    bnd = 1'b0;
    drop_now = (q.rcnt == 2'h0) ? q.fev : q.drop;
    interrupt_status = (q.pend & ~q.mask & INTERRUPT_STATUS_CLR) | {5'h00, q.cmd_ind_change, 1'b0, |q.extended_irq_cause};
    d.ack = req;
    d.dat = 8'h00;
    bit_t = q.div == 8'(DCL_DIV - 1);
    d.div = bit_t ? 8'h00 : q.div + 8'h01;

    // =====================================================================
    // Register reads
    if (rd) begin
      if (ix <= IX_WIN_LAST) begin
        d.dat = q.rxm[q.rd[5:0]];
        d.rd = q.rd + 7'h01;
      end else begin
        case (ix)
          IX_IRQ: begin
            d.dat = interrupt_status;
            clr = interrupt_status & INTERRUPT_STATUS_CLR;
          end
          IX_CTRL: d.dat = {q.ovf, ~q.go, auto & q.rnr, q.remote_not_ready,
                            used <= RXD - MBR_MIN, 3'h0};
          IX_MODE: d.dat = {q.mds, q.timer_mode_sel, q.rac, 3'h0};
          IX_TIMER: d.dat = q.tval;
          IX_EXT: begin
            d.dat = q.extended_irq_cause;
            d.extended_irq_cause = 8'h00;
          end
          IX_CNT: d.dat = {1'b0, q.bend - q.base};
          IX_CI0: begin
            d.dat = {4'h0, q.ci0};
            d.cmd_ind_change = 1'b0;
          end
          IX_CI1: begin
            d.dat = {4'h0, q.ci1};
            d.cmd_ind_change = 1'b0;
          end
          default: d.dat = 8'h00;
        endcase
      end
    end

    // =====================================================================
    // Register writes
    if (wr) begin
      if (ix <= IX_WIN_LAST) begin
        d.txm[q.twp[4:0]] = wb_dat_i[7:0];
        d.twp = {q.twp[5] | (&q.twp[4:0]), q.twp[4:0] + 5'h01};
        d.ovf = q.ovf | q.twp[5];
      end
      case (ix)
        IX_IRQ: d.mask = wb_dat_i[7:0];
        IX_MODE: begin
          d.mds = wb_dat_i[7:5];
          d.timer_mode_sel = wb_dat_i[4];
          d.rac = wb_dat_i[3];
        end
        IX_TIMER: begin
          d.tval = wb_dat_i[7:0];
          d.trun = 1'b0;
        end
        default: d.rnr = q.rnr;
      endcase
    end

    // =====================================================================
    // Commands, all taken in one clock
    // single cycle execution
    if (ix == IX_CTRL && wr) begin
      d.rnr = cmd[C_RNR];
    end
    if (cmd[C_RMC] && q.bout) begin
      d.base = q.bend;
      d.rd = q.bend;
      d.bout = 1'b0;
    end
    if (cmd[C_STI]) begin
      d.trun = 1'b1;
      d.tunit = 23'h0;
      d.tcnt = 5'h00;
      d.sresp = q.sresp | q.timer_mode_sel;
      d.spoll = q.spoll | q.timer_mode_sel;
    end
    if (cmd[C_XTF] || (cmd[C_XIF] && auto)) begin
      d.go = 1'b1;
      d.trp = 6'h00;
      d.fin = cmd[C_XME];
      if (q.ns == NX_IDLE) begin
        d.ifr = ~cmd[C_XTF];
      end
    end

    // =====================================================================
    // Receive path
    if (rx_i.vld && q.rac && !cmd[C_RX_RESET]) begin
      d.rcnt = q.rcnt + {1'b0, ~&q.rcnt};
      if (drop_now || used == RXD) begin
        d.drop = 1'b1;
        d.extended_irq_cause[E_RFO] = 1'b1;
      end else begin
        d.drop = 1'b0;
        d.rxm[q.wp[5:0]] = rx_i.dat;
        d.wp = q.wp + 7'h01;
      end
      if (q.rcnt == alen) begin
        d.ctl = rx_i.dat;
      end
    end
    if (rx_i.eof && q.rac && !cmd[C_RX_RESET]) begin
      d.rcnt = 2'h0;
      d.drop = 1'b0;
      if (!q.drop) begin
        d.fev = 1'b1;
        d.fep = q.wp;
      end
      if (!q.drop && auto && q.rcnt > alen) begin
        if (!q.ctl[0]) begin
          d.vr = q.vr + 3'h1;
          d.sresp = 1'b1;
        end else if (q.ctl[1:0] == FT_S) begin
          d.remote_not_ready = nrr;
          set[B_RSC] = nrr != q.remote_not_ready;
          d.sresp = q.sresp | q.ctl[4];
        end
        if (q.await && q.ctl[1:0] != 2'h3 && q.ctl[7:5] == q.vs) begin
          d.await = 1'b0;
          d.trun = 1'b0;
          set[B_XPR] = 1'b1;
        end
      end
    end
    if (!q.bout && !cmd[C_RX_RESET]) begin
      if (q.fev && (q.fep - q.base) <= RX_BLK) begin
        set[B_RME] = 1'b1;
        d.bend = q.fep;
        d.bout = 1'b1;
        d.fev = 1'b0;
      end else if (used > RX_BLK) begin
        // A block waits for a byte beyond it, so a 32-byte frame ends as one.
        set[B_RPF] = 1'b1;
        d.bend = q.base + RX_BLK;
        d.bout = 1'b1;
      end
    end

    // =====================================================================
    // Transmit serialiser
    if (bit_t && q.ns != NX_IDLE) begin
      if (q.ones == STUFF_ONES) begin
        d.line = 1'b0;
        d.ones = 3'h0;
      end else begin
        d.line = b;
        d.ones = (b && q.stf) ? q.ones + 3'h1 : 3'h0;
        d.sh = {1'b0, q.sh[7:1]};
        d.bc = q.bc + 3'h1;
        bnd = q.bc == 3'h7;
        if (q.crcen) begin
          d.crc = {1'b0, q.crc[15:1]} ^ (fb ? CRC_POLY : 16'h0000);
        end
      end
    end else if (bit_t) begin
      d.line = 1'b1;
      d.ones = 3'h0;
      if (q.sresp && auto) begin
        d.sfr = 1'b1;
        d.sresp = 1'b0;
        ld = 1'b1;
        lb = FLAG;
        d.ns = NX_HDR0;
      end else if (q.go) begin
        ld = 1'b1;
        lb = FLAG;
        d.ns = q.ifr ? NX_HDR0 : NX_DATA;
      end
      d.crc = CRC_INIT;
    end
    if (bnd) begin
      ld = 1'b1;
      ls = 1'b1;
      lc = 1'b1;
      case (q.ns)
        NX_HDR0: begin
          lb = LOCAL_ADDR;
          d.ns = NX_HDR1;
        end
        NX_HDR1: begin
          // RR or RNR by command bit
          lb = q.sfr ? {q.vr, q.spoll, q.rnr ? S_RNR : S_RR, FT_S}
                     : {q.vr, 1'b0, q.vs, 1'b0};
          d.spoll = q.spoll & ~q.sfr;
          d.ns = NX_DATA;
        end
        NX_DATA: begin
          if (!q.sfr && q.go && q.trp != tlen) begin
            lb = q.txm[q.trp[4:0]];
            d.trp = q.trp + 6'h01;
            if (q.trp + 6'h01 == tlen) begin
              d.go = 1'b0;
              d.twp = 6'h00;
              d.ovf = 1'b0;
              set[B_XPR] = ~q.fin;
            end
          end else if (q.sfr || q.fin) begin
            lb = ~q.crc[7:0];
            lc = 1'b0;
            d.ns = NX_CRC1;
          end else begin
            ld = 1'b0;
            d.line = 1'b1;
            d.ns = NX_IDLE;
            d.extended_irq_cause[E_XDU] = 1'b1;
            d.go = 1'b0;
          end
        end
        NX_CRC1: begin
          lb = ~q.crc[15:8];
          lc = 1'b0;
          d.ns = NX_FLAG;
        end
        NX_FLAG: begin
          lb = FLAG;
          ls = 1'b0;
          lc = 1'b0;
          d.ns = NX_END;
        end
        default: begin
          ld = 1'b0;
          d.ns = NX_IDLE;
          d.fin = 1'b0;
          d.sfr = 1'b0;
          if (!q.sfr && q.ifr) begin
            d.await = 1'b1;
            d.vs = q.vs + 3'h1;
            d.trun = d.trun | q.timer_mode_sel;
            d.tunit = 23'h0;
            d.tcnt = 5'h00;
          end else if (!q.sfr) begin
            set[B_XPR] = 1'b1;
          end
        end
      endcase
    end
    if (ld) begin
      d.sh = lb;
      d.bc = 3'h0;
      d.stf = ls;
      d.crcen = lc;
    end
    if (cmd[C_TX_RESET]) begin
      d.ns = NX_IDLE;
      d.go = 1'b0;
      d.fin = 1'b0;
      d.twp = 6'h00;
      d.trp = 6'h00;
      d.ovf = 1'b0;
      d.await = 1'b0;
      d.sfr = 1'b0;
      d.line = 1'b1;
    end
    if (cmd[C_RX_RESET]) begin
      d.wp = 7'h00;
      d.base = 7'h00;
      d.rd = 7'h00;
      d.bend = 7'h00;
      d.bout = 1'b0;
      d.fev = 1'b0;
      d.drop = 1'b0;
      d.rcnt = 2'h0;
      if (auto) begin
        d.vs = 3'h0;
        d.vr = 3'h0;
      end
    end

    // =====================================================================
    // Timer: counts units of one T1 step until tval[4:0] + 1 of them have passed.
    if (q.trun) begin
      d.tunit = q.tunit + 23'h1;
      if (q.tunit == 23'(T1_CYC - 1)) begin
        d.tunit = 23'h0;
        d.tcnt = q.tcnt + 5'h01;
        if (q.tcnt == q.tval[4:0]) begin
          d.trun = 1'b0;
          set[B_TIN] = 1'b1;
          d.sresp = q.sresp | (q.timer_mode_sel & q.await);
          d.spoll = q.spoll | (q.timer_mode_sel & q.await);
        end
      end
    end

    // =====================================================================
    // Channel change and interrupt collection
    d.ci0 = ci0_i;
    d.ci1 = ci1_i;
    if (ci0_i != q.ci0 || ci1_i != q.ci1) begin
      d.cmd_ind_change = 1'b1;
    end
    // Set wins over the clear done by a status read in the same cycle.
    d.pend = (q.pend & ~clr) | set;
    // masked sources never reach the pin
    src = d.pend | {5'h00, d.cmd_ind_change, 1'b0, |d.extended_irq_cause};
    d.irq = |(src & ~d.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = {24'h000000, q.dat};
  assign tx_bit_o = q.line;
  assign int_o = q.irq;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  win_read_a: assert property (rd && ix <= IX_WIN_LAST |=> q.rd == $past(q.rd) + 7'h01)
    else $error("receive read pointer did not advance");
  interrupt_status_clear_a: assert property (rd && ix == IX_IRQ && !q.mask[B_RME] && !set[B_RME] |=> !q.pend[B_RME])
    else $error("message end bit not cleared by status read");
  irq_pin_a: assert property (int_o == |((q.pend | {5'h00, q.cmd_ind_change, 1'b0, |q.extended_irq_cause}) & ~q.mask))
    else $error("interrupt pin disagrees with unmasked status");
  pool_full_a: assert property (set[B_RPF] |=> q.bend - q.base == RX_BLK && q.bout)
    else $error("pool full announced without a full block");
  buf_ready_a: assert property (rd && ix == IX_CTRL |=> wb_dat_o[3] == ($past(used) <= RXD - MBR_MIN))
    else $error("buffer ready bit wrong");
  tx_ovf_a: assert property (wr && ix <= IX_WIN_LAST && q.twp[5] && !cmd[C_TX_RESET] |=> q.ovf)
    else $error("transmit overflow not flagged");
  tx_reset_a: assert property (cmd[C_TX_RESET] |=> q.ns == NX_IDLE && !q.go ##1 tx_bit_o)
    else $error("transmitter reset did not abort");
  stuff_bit_a: assert property (bit_t && q.ns != NX_IDLE && q.ones == STUFF_ONES && !cmd[C_TX_RESET] |=> !tx_bit_o)
    else $error("no zero inserted after five ones");
  underrun_a: assert property (bnd && q.ns == NX_DATA && !q.go && !q.fin && !q.sfr && !cmd[C_TX_RESET] |=> q.extended_irq_cause[E_XDU] && q.ns == NX_IDLE)
    else $error("underrun not aborted");
endmodule

// ===== inc/hfc_pkg.sv
// Register map, field positions, timing and types of the HDLC FIFO block.
package hfc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IX_WIN_LAST = 6'h1F;
  localparam logic [5:0] IX_IRQ = 6'h20;
  localparam logic [5:0] IX_CTRL = 6'h21;
  localparam logic [5:0] IX_MODE = 6'h22;
  localparam logic [5:0] IX_TIMER = 6'h23;
  localparam logic [5:0] IX_EXT = 6'h24;
  localparam logic [5:0] IX_CNT = 6'h25;
  localparam logic [5:0] IX_CI0 = 6'h31;
  localparam logic [5:0] IX_CI1 = 6'h33;
  // Interrupt status bit positions.
  localparam int B_RME = 7;
  localparam int B_RPF = 6;
  localparam int B_RSC = 5;
  localparam int B_XPR = 4;
  localparam int B_TIN = 3;
  localparam logic [7:0] INTERRUPT_STATUS_CLR = 8'hFA;
  // Command bit positions.
  localparam int C_RMC = 7;
  localparam int C_RX_RESET = 6;
  localparam int C_RNR = 5;
  localparam int C_STI = 4;
  localparam int C_XTF = 3;
  localparam int C_XIF = 2;
  localparam int C_XME = 1;
  localparam int C_TX_RESET = 0;
  // Extended cause bit positions.
  localparam int E_XDU = 6;
  localparam int E_RFO = 4;
  // Sizes.
  localparam logic [6:0] RXD = 7'h40;
  localparam logic [6:0] RX_BLK = 7'h20;
  localparam logic [6:0] MBR_MIN = 7'h10;
  localparam logic [5:0] POOL = 6'h20;
  // Framing.
  localparam logic [7:0] FLAG = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [1:0] S_RR = 2'h0;
  localparam logic [1:0] S_RNR = 2'h1;
  localparam logic [1:0] FT_S = 2'h1;
  localparam logic [1:0] MDS_AUTO = 2'h0;
  localparam logic [7:0] LOCAL_ADDR_DEF = 8'h00;
  // Timing: clock rate, timer unit and data clock divider.
  localparam int CLK_MHZ = 100;
  localparam int T1_UNIT_US = 64000;
  localparam int T1_UNIT_CYC = T1_UNIT_US * CLK_MHZ;
  localparam int DCL_DIV_DEF = 8;

  typedef enum logic [2:0] {
    NX_IDLE = 3'b000,
    NX_HDR0 = 3'b001,
    NX_HDR1 = 3'b010,
    NX_DATA = 3'b011,
    NX_CRC1 = 3'b100,
    NX_FLAG = 3'b101,
    NX_END = 3'b110
  } hfc_nx_t;

  typedef struct packed {
    logic vld;
    logic eof;
    logic [7:0] dat;
  } hfc_rx_t;

  typedef struct packed {
    logic ack;
    logic [7:0] dat;
    logic irq;
    logic [7:0] pend;
    logic [7:0] mask;
    logic cmd_ind_change;
    logic [7:0] extended_irq_cause;
    logic [2:0] mds;
    logic timer_mode_sel;
    logic rac;
    logic rnr;
    logic [7:0] tval;
    logic [RXD-1:0][7:0] rxm;
    logic [6:0] wp;
    logic [6:0] base;
    logic [6:0] rd;
    logic [6:0] bend;
    logic bout;
    logic fev;
    logic [6:0] fep;
    logic drop;
    logic [1:0] rcnt;
    logic [7:0] ctl;
    logic remote_not_ready;
    logic [31:0][7:0] txm;
    logic [5:0] twp;
    logic [5:0] trp;
    logic go;
    logic fin;
    logic ifr;
    logic ovf;
    hfc_nx_t ns;
    logic [7:0] sh;
    logic [2:0] bc;
    logic stf;
    logic crcen;
    logic [2:0] ones;
    logic [15:0] crc;
    logic line;
    logic [7:0] div;
    logic sfr;
    logic sresp;
    logic spoll;
    logic await;
    logic [2:0] vs;
    logic [2:0] vr;
    logic trun;
    logic [22:0] tunit;
    logic [4:0] tcnt;
    logic [3:0] ci0;
    logic [3:0] ci1;
  } hfc_st_t;
endpackage
